/* hw/uctl_pkg.sv */
// shared constants and bus carriers for the serial port control block
package uctl_pkg;

  localparam int ADDR_W = 12;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h030;
  localparam logic [ADDR_W-1:0] TEST_OFFSET = 12'h080;
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 12'h084;

  // control register field positions
  localparam int BIT_PORT_EN = 0;
  localparam int BIT_IR_EN = 1;
  localparam int BIT_IR_LP = 2;
  localparam int BIT_LOOP = 7;
  localparam int BIT_TX_EN = 8;
  localparam int BIT_RX_EN = 9;
  localparam int BIT_DTR = 10;
  localparam int BIT_RTS = 11;
  localparam int BIT_AUX_A = 12;
  localparam int BIT_AUX_B = 13;
  localparam int BIT_RTS_FLOW = 14;
  localparam int BIT_CTS_FLOW = 15;
  localparam logic [15:0] CTRL_RESET = 16'h0300;
  localparam logic [15:0] CTRL_WMASK = 16'hff87;

  // test control register
  localparam int BIT_IR_TEST = 0;
  localparam logic TEST_RESET = 1'h0;

  // infrared timing: bit length in ticks of the 16x bit-rate enable, pulse length in ticks of the selected rate
  localparam int IR_BIT_TICKS = 16;
  localparam int IR_PULSE_TICKS = 3;
  localparam logic [1:0] IR_PULSE_LAST = 2'(IR_PULSE_TICKS - 1);
  localparam logic [3:0] IR_BIT_LAST = 4'(IR_BIT_TICKS - 1);

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register selector codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_TEST = 2'h2;
  localparam logic [1:0] SEL_STAT = 2'h3;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } uctl_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } uctl_axil_rsp_s;

endpackage

/* hw/uctl_port_control.sv */
// serial port control register with line steering, flow control and infrared codec
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - with cts flow on and infrared off, new characters start only while clear-to-send is asserted
// - with rts flow on, request-to-send is asserted only while receive fifo has space
// - aux pin b is driven to the inverse of its control bit
// - aux pin a is driven to the inverse of its control bit
// - request-to-send pin is low when its control bit is one and rts flow is off
// - terminal-ready pin is low when its control bit is one
// - receive runs only while enabled, resets enabled, finishes the current character
// - transmit runs only while enabled, resets enabled, finishes the current character
// - loopback with infrared and test override feeds inverted infrared output to input
// - loopback without infrared feeds serial transmit data to receive data
// - loopback feeds modem outputs back to modem status inputs; resets off
// - normal infrared mode sends each zero bit as a 3/16 bit-period high pulse
// - low-power infrared mode sends zero bits as three low-power reference periods
// - infrared disabled keeps infrared output low and ignores infrared input
// - infrared enabled holds serial transmit high, ignores serial and modem inputs
// - infrared enable has no effect while the port is globally disabled and no character is under way
// - global enable resets off, finishes current character, then gates all traffic
module uctl_port_control (
  input wire logic clock,
  input wire logic reset_n,
  input wire uctl_pkg::uctl_axil_req_s axil_req,
  output var uctl_pkg::uctl_axil_rsp_s axil_rsp,
  input wire logic baud16_tick,
  input wire logic low_power_baud_ref,
  input wire logic core_tx_bit,
  input wire logic core_tx_bit_stb,
  input wire logic core_tx_busy,
  input wire logic core_rx_busy,
  input wire logic rx_fifo_space,
  output var logic tx_start_ok,
  output var logic rx_start_ok,
  output var logic core_rx_bit,
  output var logic [3:0] modem_status,
  input wire logic clear_to_send_pin_n,
  input wire logic dsr_pin_n,
  input wire logic dcd_pin_n,
  input wire logic ring_pin_n,
  input wire logic serial_rx_pin,
  input wire logic infrared_in,
  output var logic serial_tx_pin,
  output var logic infrared_out_n,
  output var logic request_send_pin_n,
  output var logic terminal_ready_pin_n,
  output var logic aux_modem_pin_a_n,
  output var logic aux_modem_pin_b_n
);

  function automatic logic [1:0] reg_sel(input logic [uctl_pkg::ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = uctl_pkg::SEL_NONE;
    if (addr == uctl_pkg::CTRL_OFFSET) sel = uctl_pkg::SEL_CTRL;
    if (addr == uctl_pkg::TEST_OFFSET) sel = uctl_pkg::SEL_TEST;
    if (addr == uctl_pkg::STAT_OFFSET) sel = uctl_pkg::SEL_STAT;
    return sel;
  endfunction

  logic [15:0] ctrl_reg;
  logic test_reg;
  logic [5:0] pin_meta_reg;
  logic [5:0] pin_sync_reg;
  logic ir_pulse_reg;
  logic [1:0] ir_cnt_reg;
  logic ir_prev_reg;
  logic dec_low_reg;
  logic [3:0] dec_cnt_reg;
  logic aw_hold_reg;
  logic [uctl_pkg::ADDR_W-1:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // every pin input crosses in through two flops; idle levels are all high
  wire [5:0] pin_raw = {infrared_in, serial_rx_pin, ring_pin_n, dcd_pin_n, dsr_pin_n,
    clear_to_send_pin_n};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= 6'h3f;
      pin_sync_reg <= 6'h3f;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire port_global_enable = ctrl_reg[uctl_pkg::BIT_PORT_EN];
  wire infrared_codec_enable = ctrl_reg[uctl_pkg::BIT_IR_EN];
  wire infrared_low_power = ctrl_reg[uctl_pkg::BIT_IR_LP];
  wire loopback_enable = ctrl_reg[uctl_pkg::BIT_LOOP];
  wire transmit_section_enable = ctrl_reg[uctl_pkg::BIT_TX_EN];
  wire receive_section_enable = ctrl_reg[uctl_pkg::BIT_RX_EN];
  wire terminal_ready_bit = ctrl_reg[uctl_pkg::BIT_DTR];
  wire request_send_bit = ctrl_reg[uctl_pkg::BIT_RTS];
  wire aux_modem_line_a = ctrl_reg[uctl_pkg::BIT_AUX_A];
  wire aux_modem_line_b = ctrl_reg[uctl_pkg::BIT_AUX_B];
  wire request_send_flow_enable = ctrl_reg[uctl_pkg::BIT_RTS_FLOW];
  wire clear_to_send_flow_enable = ctrl_reg[uctl_pkg::BIT_CTS_FLOW];
  wire infrared_test_override = test_reg;

  // a character already under way keeps its lines until the core drops busy
  wire tx_live = (port_global_enable & transmit_section_enable) | core_tx_busy;
  wire rx_live = (port_global_enable & receive_section_enable) | core_rx_busy;
  wire ir_tx_mode = infrared_codec_enable & (port_global_enable | core_tx_busy);
  wire ir_rx_mode = infrared_codec_enable & (port_global_enable | core_rx_busy);
  wire ir_loop = loopback_enable & infrared_codec_enable & infrared_test_override;

  // flow control replaces the software bit on the request-to-send line
  wire rts_drive = request_send_flow_enable ? rx_fifo_space : request_send_bit;

  // modem status, active high: {ring, carrier, data set ready, clear to send}
  wire [3:0] modem_fed = {aux_modem_line_b, aux_modem_line_a, terminal_ready_bit, rts_drive};
  wire [3:0] modem_pins = ~pin_sync_reg[3:0];
  wire [3:0] modem_seen = loopback_enable ? modem_fed :
    (ir_rx_mode ? 4'h0 : modem_pins);

  // infrared has no cts line, so flow gating only applies on the wired link
  wire cts_ok = ~clear_to_send_flow_enable | ir_tx_mode | modem_seen[0];
  wire tx_start_next = port_global_enable & transmit_section_enable & cts_ok;
  wire rx_start_next = port_global_enable & receive_section_enable;

  wire serial_tx_next = (~tx_live | ir_tx_mode) ? 1'b1 : core_tx_bit;
  wire ir_out_next = ir_tx_mode & ir_pulse_reg;

  // infrared encoder: a zero bit fires a pulse of three ticks of the selected rate
  wire ir_tick = infrared_low_power ? low_power_baud_ref : baud16_tick;
  wire ir_start = ir_tx_mode & tx_live & core_tx_bit_stb & ~core_tx_bit;
  wire ir_pulse_end = ir_pulse_reg & ir_tick & (ir_cnt_reg == uctl_pkg::IR_PULSE_LAST);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ir_pulse_reg <= 1'b0;
      ir_cnt_reg <= 2'h0;
    end else if (ir_start) begin
      ir_pulse_reg <= 1'b1;
      ir_cnt_reg <= 2'h0;
    end else if (ir_pulse_reg & ir_tick) begin
      ir_pulse_reg <= ~ir_pulse_end;
      ir_cnt_reg <= ir_cnt_reg + 2'h1;
    end
  end

  // infrared decoder: a falling edge marks a zero held for one bit period
  wire ir_in_eff = ir_loop ? ~ir_pulse_reg : pin_sync_reg[5];
  wire ir_fall = ir_prev_reg & ~ir_in_eff & ir_rx_mode & rx_live;
  wire dec_end = dec_low_reg & baud16_tick & (dec_cnt_reg == uctl_pkg::IR_BIT_LAST);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ir_prev_reg <= 1'b1;
      dec_low_reg <= 1'b0;
      dec_cnt_reg <= 4'h0;
    end else begin
      ir_prev_reg <= ir_in_eff;
      if (ir_fall) begin
        dec_low_reg <= 1'b1;
        dec_cnt_reg <= 4'h0;
      end else if (dec_low_reg & baud16_tick) begin
        dec_low_reg <= ~dec_end;
        dec_cnt_reg <= dec_cnt_reg + 4'h1;
      end
    end
  end

  wire wired_rx = loopback_enable ? core_tx_bit : pin_sync_reg[4];
  wire rx_bit_next = ~rx_live ? 1'b1 : (ir_rx_mode ? ~dec_low_reg : wired_rx);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_start_ok <= 1'b0;
      rx_start_ok <= 1'b0;
      core_rx_bit <= 1'b1;
      modem_status <= 4'h0;
      serial_tx_pin <= 1'b1;
      infrared_out_n <= 1'b0;
      request_send_pin_n <= 1'b1;
      terminal_ready_pin_n <= 1'b1;
      aux_modem_pin_a_n <= 1'b1;
      aux_modem_pin_b_n <= 1'b1;
    end else begin
      tx_start_ok <= tx_start_next;
      rx_start_ok <= rx_start_next;
      core_rx_bit <= rx_bit_next;
      modem_status <= modem_seen;
      serial_tx_pin <= serial_tx_next;
      infrared_out_n <= ir_out_next;
      request_send_pin_n <= ~rts_drive;
      terminal_ready_pin_n <= ~terminal_ready_bit;
      aux_modem_pin_a_n <= ~aux_modem_line_a;
      aux_modem_pin_b_n <= ~aux_modem_line_b;
    end
  end

  // register bus slave: address and data are caught in either order
  wire aw_take = axil_req.awvalid & axil_rsp.awready;
  wire w_take = axil_req.wvalid & axil_rsp.wready;
  wire do_write = aw_hold_reg & w_hold_reg & ~axil_rsp.bvalid;
  wire aw_hold_next = aw_take | (aw_hold_reg & ~do_write);
  wire w_hold_next = w_take | (w_hold_reg & ~do_write);
  wire [1:0] wr_sel = reg_sel(aw_addr_reg);
  wire [1:0] rd_sel = reg_sel(axil_req.araddr);
  wire ar_take = axil_req.arvalid & axil_rsp.arready;
  wire r_busy_next = ar_take | (axil_rsp.rvalid & ~axil_req.rready);
  wire b_busy_next = do_write | (axil_rsp.bvalid & ~axil_req.bready);

  wire [15:0] ctrl_lanes = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [15:0] ctrl_mask = ctrl_lanes & uctl_pkg::CTRL_WMASK;
  wire [15:0] ctrl_next = (ctrl_reg & ~ctrl_mask) | (w_data_reg[15:0] & ctrl_mask);
  wire [7:0] stat_word = {dec_low_reg, ir_pulse_reg, rx_start_ok, tx_start_ok, modem_status};
  wire [31:0] rd_word = (rd_sel == uctl_pkg::SEL_CTRL) ? {16'h0000, ctrl_reg} :
    (rd_sel == uctl_pkg::SEL_TEST) ? {31'h0, test_reg} :
    (rd_sel == uctl_pkg::SEL_STAT) ? {24'h000000, stat_word} : 32'h00000000;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      if (aw_take) aw_addr_reg <= axil_req.awaddr;
      if (w_take) begin
        w_data_reg <= axil_req.wdata;
        w_strb_reg <= axil_req.wstrb;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= uctl_pkg::CTRL_RESET;
      test_reg <= uctl_pkg::TEST_RESET;
    end else if (do_write) begin
      if (wr_sel == uctl_pkg::SEL_CTRL) ctrl_reg <= ctrl_next;
      if ((wr_sel == uctl_pkg::SEL_TEST) & w_strb_reg[0]) begin
        test_reg <= w_data_reg[uctl_pkg::BIT_IR_TEST];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      axil_rsp <= '0;
      axil_rsp.awready <= 1'b1;
      axil_rsp.wready <= 1'b1;
      axil_rsp.arready <= 1'b1;
    end else begin
      axil_rsp.awready <= ~aw_hold_next;
      axil_rsp.wready <= ~w_hold_next;
      axil_rsp.bvalid <= b_busy_next;
      axil_rsp.arready <= ~r_busy_next;
      axil_rsp.rvalid <= r_busy_next;
      // status register is read-only, so a write there is refused too
      if (do_write) begin
        axil_rsp.bresp <= ((wr_sel == uctl_pkg::SEL_NONE) | (wr_sel == uctl_pkg::SEL_STAT)) ?
          uctl_pkg::RESP_SLVERR : uctl_pkg::RESP_OKAY;
      end
      if (ar_take) begin
        axil_rsp.rdata <= rd_word;
        axil_rsp.rresp <= (rd_sel == uctl_pkg::SEL_NONE) ? uctl_pkg::RESP_SLVERR :
          uctl_pkg::RESP_OKAY;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_pulse_begins;
    ir_start;
  endsequence

  sequence s_loop_pulse;
    ir_loop && rx_live && ir_rx_mode && $rose(ir_pulse_reg);
  endsequence

  a_cts_gate_start: assert property (
    (clear_to_send_flow_enable && !ir_tx_mode && !modem_seen[0]) |=> !tx_start_ok)
    else $error("transmit start allowed without clear-to-send");

  a_rts_flow_space: assert property (
    (request_send_flow_enable && !rx_fifo_space) |=> request_send_pin_n)
    else $error("request-to-send asserted with no fifo space");

  a_aux_b_pin: assert property (
    $changed(aux_modem_line_b) |=> (aux_modem_pin_b_n != $past(aux_modem_pin_b_n)))
    else $error("aux pin b did not follow its bit");

  a_aux_a_pin: assert property (
    1'b1 |=> (aux_modem_pin_a_n == !$past(aux_modem_line_a)))
    else $error("aux pin a not inverse of its bit");

  a_rts_pin_level: assert property (
    !request_send_flow_enable |=> (request_send_pin_n == !$past(request_send_bit)))
    else $error("request-to-send pin wrong level");

  a_dtr_pin_level: assert property (
    terminal_ready_bit [*2] |-> !terminal_ready_pin_n)
    else $error("terminal-ready pin not low");

  a_rx_gate_start: assert property (
    !(port_global_enable && receive_section_enable) |=> !rx_start_ok)
    else $error("receive start allowed while disabled");

  a_tx_char_finish: assert property (
    (core_tx_busy && !infrared_codec_enable) |=> (serial_tx_pin == $past(core_tx_bit)))
    else $error("character cut short on transmit pin");

  a_ir_loop_feed: assert property (
    s_loop_pulse |=> dec_low_reg ##1 !core_rx_bit)
    else $error("infrared loopback did not reach receiver");

  a_serial_loop_feed: assert property (
    (loopback_enable && rx_live && !ir_rx_mode) |=> (core_rx_bit == $past(core_tx_bit)))
    else $error("serial loopback data mismatch");

  a_modem_loop_feed: assert property (
    loopback_enable |=> (modem_status == $past(modem_fed)))
    else $error("modem loopback mismatch");

  a_ir_pulse_width: assert property (
    s_pulse_begins ##1 ir_pulse_reg [*1] |-> ir_pulse_reg throughout (ir_cnt_reg != 2'h3))
    else $error("infrared pulse ran past three ticks");

  a_ir_pulse_end: assert property (
    $fell(ir_pulse_reg) |-> ($past(ir_cnt_reg) == uctl_pkg::IR_PULSE_LAST && $past(ir_tick))
      || $past(ir_start))
    else $error("infrared pulse ended off count");

  a_ir_off_dark: assert property (
    !infrared_codec_enable |=> !infrared_out_n)
    else $error("infrared output lit while codec off");

  a_ir_tx_mark: assert property (
    ir_tx_mode |=> serial_tx_pin)
    else $error("serial transmit not marking in infrared mode");

  a_port_off_quiet: assert property (
    (!port_global_enable && !core_tx_busy) |=> (serial_tx_pin && !infrared_out_n && !tx_start_ok))
    else $error("traffic while port disabled");

  a_reserved_zero: assert property (
    (ctrl_reg & ~uctl_pkg::CTRL_WMASK) == 16'h0000)
    else $error("reserved control bits set");

endmodule // uctl_port_control
`default_nettype wire

/* verif/uctl_line_partner.sv */
// far-side model: modem status lines, serial receive line and infrared receiver
`timescale 1ns/1ps
`default_nettype none
module uctl_line_partner (
  input wire logic clock,
  input wire logic [3:0] mdm_n,
  input wire logic rx_cmd,
  input wire logic ir_flash,
  output var logic clear_to_send_pin_n,
  output var logic dsr_pin_n,
  output var logic dcd_pin_n,
  output var logic ring_pin_n,
  output var logic serial_rx_pin,
  output var logic infrared_in
);
  initial begin
    {ring_pin_n, dcd_pin_n, dsr_pin_n, clear_to_send_pin_n} = 4'hf;
    serial_rx_pin = 1'b1;
    infrared_in = 1'b1;
  end
  // lines change a cycle late, as across a cable
  always @(posedge clock) begin
    {ring_pin_n, dcd_pin_n, dsr_pin_n, clear_to_send_pin_n} <= mdm_n;
    serial_rx_pin <= rx_cmd;
    // receiver idles high; light seen pulls it low
    infrared_in <= ~ir_flash;
  end
endmodule // uctl_line_partner
`default_nettype wire

/* verif/uctl_port_control_tb.sv */
// self-checking bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
module uctl_port_control_tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic baud16_tick = 1'b0, low_power_baud_ref = 1'b0, core_tx_bit = 1'b1;
  logic core_tx_bit_stb = 1'b0, core_tx_busy = 1'b0, core_rx_busy = 1'b0;
  logic rx_fifo_space = 1'b1, rx_cmd = 1'b1, ir_flash = 1'b0;
  logic [3:0] mdm_n = 4'hf;
  logic tx_start_ok, rx_start_ok, core_rx_bit, serial_tx_pin, infrared_out_n;
  logic request_send_pin_n, terminal_ready_pin_n, aux_modem_pin_a_n, aux_modem_pin_b_n;
  logic clear_to_send_pin_n, dsr_pin_n, dcd_pin_n, ring_pin_n, serial_rx_pin, infrared_in;
  logic [3:0] modem_status;
  logic [1:0] resp;
  logic [31:0] rdat, ctl_m, v;
  logic s;
  int seed = 32'hdf28;
  int err_count = 0;
  int compares = 0;
  int tcnt = 0;
  uctl_pkg::uctl_axil_req_s req = '0;
  uctl_pkg::uctl_axil_rsp_s rsp;

  uctl_port_control uut (
    .clock, .reset_n, .axil_req(req), .axil_rsp(rsp), .baud16_tick, .low_power_baud_ref,
    .core_tx_bit, .core_tx_bit_stb, .core_tx_busy, .core_rx_busy, .rx_fifo_space,
    .tx_start_ok, .rx_start_ok, .core_rx_bit, .modem_status, .clear_to_send_pin_n,
    .dsr_pin_n, .dcd_pin_n, .ring_pin_n, .serial_rx_pin, .infrared_in, .serial_tx_pin,
    .infrared_out_n, .request_send_pin_n, .terminal_ready_pin_n, .aux_modem_pin_a_n,
    .aux_modem_pin_b_n
  );
  uctl_line_partner far_end (
    .clock, .mdm_n, .rx_cmd, .ir_flash, .clear_to_send_pin_n, .dsr_pin_n, .dcd_pin_n,
    .ring_pin_n, .serial_rx_pin, .infrared_in
  );

  initial begin
    forever #5 clock = ~clock;
  end
  // periods 4 and 7 keep the two pulse widths apart
  always @(posedge clock) begin
    tcnt <= tcnt + 1;
    baud16_tick <= (tcnt % 4 == 3);
    low_power_baud_ref <= (tcnt % 7 == 6);
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: register %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_line(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: lines %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, wd;
    @(posedge clock);
    aw = 1'b1;
    wd = 1'b1;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (aw || wd) begin
      @(posedge clock);
      aw &= !rsp.awready;
      wd &= !rsp.wready;
      req.awvalid <= aw;
      req.wvalid <= wd;
    end
    while (rsp.bvalid !== 1'b1) @(posedge clock);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    @(posedge clock);
    while (rsp.arready !== 1'b1) @(posedge clock);
    req.arvalid <= 1'b0;
    @(posedge clock);
    while (rsp.rvalid !== 1'b1) @(posedge clock);
    rdat = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic wctl(input logic [31:0] d);
    wr(uctl_pkg::CTRL_OFFSET, d);
    ctl_m = d & 32'(uctl_pkg::CTRL_WMASK);
    chk_reg(32'(resp), 32'(uctl_pkg::RESP_OKAY));
  endtask
  // one partner stage, two synchroniser stages and one output register stage
  task automatic settle;
    repeat (4) @(posedge clock);
  endtask

  task automatic line_check;
    logic rts_n;
    logic [3:0] ms;
    rts_n = ctl_m[14] ? ~rx_fifo_space : ~ctl_m[11];
    ms = ctl_m[7] ? {ctl_m[13:12], ctl_m[10], ~rts_n} : ~mdm_n;
    chk_line({aux_modem_pin_b_n, aux_modem_pin_a_n, request_send_pin_n, terminal_ready_pin_n},
      {~ctl_m[13:12], rts_n, ~ctl_m[10]});
    chk_line(modem_status, ms);
    chk_line({tx_start_ok, serial_tx_pin, core_rx_bit, rx_start_ok},
      {~ctl_m[15] | ms[0], core_tx_bit, ctl_m[7] ? core_tx_bit : serial_rx_pin,
      ctl_m[0] & ctl_m[9]});
  endtask

  task automatic ir_case(input logic [31:0] c, input logic st, fl, input int lo, hi,
      input logic s_exp);
    int n;
    rx_cmd <= ~c[1];
    wctl(c);
    @(posedge clock);
    core_tx_bit <= 1'b0;
    core_tx_bit_stb <= st;
    ir_flash <= fl;
    @(posedge clock);
    core_tx_bit_stb <= 1'b0;
    ir_flash <= 1'b0;
    n = 0;
    s = 1'b0;
    // long enough for the decoder's zero hold to run out
    repeat (120) begin
      @(posedge clock);
      n += int'(infrared_out_n === 1'b1);
      s |= (core_rx_bit === 1'b0);
    end
    chk_line({3'h0, n >= lo && n <= hi}, 4'h1);
    chk_line({3'h0, s}, {3'h0, s_exp});
  endtask

  task automatic results;
    $display("compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results;
  end

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    chk_line({tx_start_ok, serial_tx_pin, infrared_out_n, request_send_pin_n}, 4'h5);
    rd(uctl_pkg::CTRL_OFFSET);
    chk_reg(rdat, 32'h0000_0300);
    rd(12'h0fc);
    chk_reg(32'(resp), 32'(uctl_pkg::RESP_SLVERR));
    wr(uctl_pkg::STAT_OFFSET, 32'h0000_00ff);
    chk_reg(32'(resp), 32'(uctl_pkg::RESP_SLVERR));
    wctl(32'hffff_ffff);
    rd(uctl_pkg::CTRL_OFFSET);
    chk_reg(rdat, 32'h0000_ff87);
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      mdm_n <= v[3:0];
      core_tx_bit <= v[4];
      rx_cmd <= v[5];
      rx_fifo_space <= v[6];
      wctl({v[31:10], 2'h3, v[7:3], 3'h1});
      settle;
      line_check;
      rd(uctl_pkg::CTRL_OFFSET);
      chk_reg(rdat, ctl_m);
    end
    // sections off, then the whole port off, each in mid-character
    for (int i = 0; i < 2; i++) begin
      wctl(32'h0301);
      core_tx_busy <= 1'b1;
      core_rx_busy <= 1'b1;
      core_tx_bit <= 1'b0;
      rx_cmd <= 1'b0;
      settle;
      wctl(i == 0 ? 32'h0000_0001 : 32'h0000_0300);
      settle;
      chk_line({tx_start_ok, serial_tx_pin, core_rx_bit, 1'b0}, 4'h0);
      core_tx_busy <= 1'b0;
      core_rx_busy <= 1'b0;
      settle;
      chk_line({tx_start_ok, serial_tx_pin, core_rx_bit, rx_start_ok}, 4'h6);
      // loopback and infrared are off here, so status shows the partner's modem lines
      rd(uctl_pkg::STAT_OFFSET);
      chk_reg(rdat, {28'h0, ~mdm_n});
    end
    ir_case(32'h0303, 1'b1, 1'b0, 8, 13, 1'b0);
    chk_line({3'h0, serial_tx_pin}, 4'h1);
    ir_case(32'h0307, 1'b1, 1'b0, 14, 22, 1'b0);
    ir_case(32'h0303, 1'b0, 1'b1, 0, 0, 1'b1);
    ir_case(32'h0301, 1'b1, 1'b1, 0, 0, 1'b0);
    ir_case(32'h0302, 1'b1, 1'b1, 0, 0, 1'b0);
    wr(uctl_pkg::TEST_OFFSET, 32'h0000_0001);
    chk_reg(32'(resp), 32'(uctl_pkg::RESP_OKAY));
    rd(uctl_pkg::TEST_OFFSET);
    chk_reg(rdat, 32'h0000_0001);
    ir_case(32'h0383, 1'b1, 1'b0, 0, 40, 1'b1);
    wr(uctl_pkg::TEST_OFFSET, 32'h0000_0000);
    rd(uctl_pkg::TEST_OFFSET);
    chk_reg(rdat, 32'h0000_0000);
    results;
  end
endmodule // uctl_port_control_tb
`default_nettype wire
